// ===== core/gp_timer.sv
/*
 * General purpose timer with halves A and B, joinable into one 32-bit
 * counter for one-shot, periodic and RTC use. Control and status bits
 * are plain ports. Assumes capture pins are asynchronous and software
 * disables a half before changing its configuration.
 */
`timescale 1ns/100ps
`default_nettype none
module gp_timer
    import gp_timer_pkg::*;
#(
    parameter int RTC_DIVIDE = RTC_DIV
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Global configuration.
    input wire logic [2:0] global_config_reg,
    // Timer A mode.
    input wire logic [1:0] a_mode_field,
    input wire logic a_capture_mode_bit,
    input wire logic a_alternate_mode_select_bit,
    // Timer B mode.
    input wire logic [1:0] b_mode_field,
    input wire logic b_capture_mode_bit,
    input wire logic b_alternate_mode_select_bit,
    // Control; enable bits are set here and may be cleared by hardware.
    input wire logic a_enable_set,
    input wire logic a_enable_clear,
    input wire logic b_enable_set,
    input wire logic b_enable_clear,
    input wire logic a_stall_bit,
    input wire logic b_stall_bit,
    input wire logic rtc_stall_override_bit,
    input wire logic [1:0] a_event_select,
    input wire logic [1:0] b_event_select,
    input wire logic a_pwm_level_invert_bit,
    input wire logic b_pwm_level_invert_bit,
    // Load, match and prescale values.
    input wire logic [31:0] a_interval_load_reg,
    input wire logic [15:0] b_interval_load_reg,
    input wire logic [31:0] a_match_reg,
    input wire logic [15:0] b_match_reg,
    input wire logic [7:0] a_prescale_reg,
    input wire logic [7:0] b_prescale_reg,
    input wire logic [7:0] a_prescale_match_reg,
    input wire logic [7:0] b_prescale_match_reg,
    // Interrupt mask and clear; clear bits are one-cycle write-one pulses.
    input wire logic [5:0] irq_mask_reg,
    input wire logic [5:0] irq_clear_reg,
    // Capture pins.
    input wire logic capture_pin_zero,
    input wire logic capture_pin_one,
    // Status outputs.
    output logic a_enable_bit,
    output logic b_enable_bit,
    output logic [5:0] raw_irq_status_reg,
    output logic [5:0] masked_irq_status_reg,
    output logic [31:0] a_timer_value_reg,
    output logic [15:0] b_timer_value_reg,
    output logic a_pwm_out,
    output logic b_pwm_out
);

    // Status bit order: A time-out, A match, A event, RTC, B time-out, B event (B match shares B event).
    localparam int ST_A_TO = 0;
    localparam int ST_A_MATCH = 1;
    localparam int ST_A_EVT = 2;
    localparam int ST_RTC = 3;
    localparam int ST_B_TO = 4;
    localparam int ST_B_EVT = 5;

    logic [1:0] pin0_s_r, pin1_s_r;
    logic a_en_r, a_en_nxt, b_en_r, b_en_nxt;
    logic [5:0] ris_r, ris_nxt;
    logic [31:0] c32_r, c32_nxt;
    logic [15:0] rtc_div_r, rtc_div_nxt;
    logic rtc_first_r, rtc_first_nxt, rtc_pin_d_r;
    logic mode16, mode32, mode_rtc, stall32;
    logic a_to, a_cm, a_ce, a_dis, b_to, b_cm, b_ce, b_dis;
    logic to32, dis32, rtc_match, rtc_sec;
    logic [15:0] a_val16, a_cnt16, b_cnt16;
    logic b_cm_unused;

    assign mode16 = global_config_reg[CFG_16BIT_BIT];
    assign mode32 = global_config_reg == CFG_32BIT;
    assign mode_rtc = global_config_reg == CFG_RTC;

    // Two-flop synchronisers for the asynchronous capture pins.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin0_s_r <= 2'b00;
            pin1_s_r <= 2'b00;
        end
        else
        begin
            pin0_s_r <= {pin0_s_r[0], capture_pin_zero};
            pin1_s_r <= {pin1_s_r[0], capture_pin_one};
        end
    end

    // Both halves are built alike; in 32-bit modes both halves idle.
    gp_timer_half #(.WIDTH(16)) u_half_a (
        .clock(clock),
        .rst_b(rst_b),
        .active(mode16),
        .enable(a_en_r && mode16),
        .stall(a_stall_bit),
        .half_mode_field(a_mode_field),
        .capture_mode_bit(a_capture_mode_bit),
        .alternate_mode_select_bit(a_alternate_mode_select_bit),
        .event_select(a_event_select),
        .pwm_level_invert_bit(a_pwm_level_invert_bit),
        .interval_load_reg(a_interval_load_reg[15:0]),
        .match_reg(a_match_reg[15:0]),
        .prescale_reg(a_prescale_reg),
        .prescale_match_reg(a_prescale_match_reg),
        .pin_sync(pin0_s_r[1]),
        .timeout_evt(a_to),
        .cap_match_evt(a_cm),
        .cap_event_evt(a_ce),
        .auto_disable(a_dis),
        .count_value(a_cnt16),
        .timer_value_reg(a_val16),
        .pwm_out(a_pwm_out)
    );

    gp_timer_half #(.WIDTH(16)) u_half_b (
        .clock(clock),
        .rst_b(rst_b),
        .active(mode16),
        .enable(b_en_r && mode16),
        .stall(b_stall_bit),
        .half_mode_field(b_mode_field),
        .capture_mode_bit(b_capture_mode_bit),
        .alternate_mode_select_bit(b_alternate_mode_select_bit),
        .event_select(b_event_select),
        .pwm_level_invert_bit(b_pwm_level_invert_bit),
        .interval_load_reg(b_interval_load_reg),
        .match_reg(b_match_reg),
        .prescale_reg(b_prescale_reg),
        .prescale_match_reg(b_prescale_match_reg),
        .pin_sync(pin1_s_r[1]),
        .timeout_evt(b_to),
        .cap_match_evt(b_cm),
        .cap_event_evt(b_ce),
        .auto_disable(b_dis),
        .count_value(b_cnt16),
        .timer_value_reg(b_timer_value_reg),
        .pwm_out(b_pwm_out)
    );

    // Half B shares a match status bit with B edge-time in this map.
    assign b_cm_unused = b_cm;

    // Stall override lets the RTC ignore both stall bits.
    assign stall32 = mode_rtc ? ((a_stall_bit || b_stall_bit) && !rtc_stall_override_bit)
        : a_stall_bit;
    assign rtc_sec = rtc_div_r == 16'(RTC_DIVIDE - 1);
    assign rtc_match = mode_rtc && a_en_r && c32_r == a_match_reg;

    // Joined 32-bit counter: one-shot, periodic and RTC.
    always_comb
    begin
        c32_nxt = c32_r;
        rtc_div_nxt = rtc_div_r;
        rtc_first_nxt = rtc_first_r;
        to32 = 1'b0;
        dis32 = 1'b0;
        if (!a_en_r || mode16)
        begin
            c32_nxt = mode_rtc && rtc_first_r ? RTC_FIRST : a_interval_load_reg;
            rtc_div_nxt = 16'h0000;
        end
        else if (mode32 && !stall32)
        begin
            if (c32_r == 32'h0000_0000)
            begin
                c32_nxt = a_interval_load_reg;
                to32 = 1'b1;
                dis32 = (a_mode_field == MODE_ONESHOT);
            end
            else
            begin
                c32_nxt = c32_r - 32'h0000_0001;
            end
        end
        else if (mode_rtc && !stall32)
        begin
            rtc_first_nxt = 1'b0;
            // The pin clock is counted on its rising edges, then divided to seconds.
            if (pin0_s_r[1] && !rtc_pin_d_r)
            begin
                rtc_div_nxt = rtc_sec ? 16'h0000 : rtc_div_r + 16'h0001;
                if (rtc_sec)
                begin
                    c32_nxt = rtc_match ? RTC_ROLL : c32_r + 32'h0000_0001;
                end
            end
        end
    end

    // Enable bits: software sets, software or hardware clears.
    always_comb
    begin
        a_en_nxt = a_en_r;
        b_en_nxt = b_en_r;
        if (a_enable_set)
        begin
            a_en_nxt = 1'b1;
        end
        if (a_enable_clear || a_dis || dis32)
        begin
            a_en_nxt = 1'b0;
        end
        if (b_enable_set)
        begin
            b_en_nxt = 1'b1;
        end
        if (b_enable_clear || b_dis)
        begin
            b_en_nxt = 1'b0;
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    always_comb
    begin
        ris_nxt = ris_r & ~irq_clear_reg;
        if (a_to || to32)
        begin
            ris_nxt[ST_A_TO] = 1'b1;
        end
        if (a_cm)
        begin
            ris_nxt[ST_A_MATCH] = 1'b1;
        end
        if (a_ce)
        begin
            ris_nxt[ST_A_EVT] = 1'b1;
        end
        if (rtc_match && rtc_sec && pin0_s_r[1] && !rtc_pin_d_r && !stall32)
        begin
            ris_nxt[ST_RTC] = 1'b1;
        end
        if (b_to)
        begin
            ris_nxt[ST_B_TO] = 1'b1;
        end
        if (b_ce || b_cm)
        begin
            ris_nxt[ST_B_EVT] = 1'b1;
        end
    end

    // State registers of the top.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_en_r <= 1'b0;
            b_en_r <= 1'b0;
            ris_r <= 6'h00;
            c32_r <= LOAD32_RESET;
            rtc_div_r <= 16'h0000;
            rtc_first_r <= 1'b1;
            rtc_pin_d_r <= 1'b0;
        end
        else
        begin
            a_en_r <= a_en_nxt;
            b_en_r <= b_en_nxt;
            ris_r <= ris_nxt;
            c32_r <= c32_nxt;
            rtc_div_r <= rtc_div_nxt;
            rtc_first_r <= rtc_first_nxt;
            rtc_pin_d_r <= pin0_s_r[1];
        end
    end

    assign a_enable_bit = a_en_r;
    assign b_enable_bit = b_en_r;
    assign raw_irq_status_reg = ris_r;
    assign masked_irq_status_reg = ris_r & irq_mask_reg;
    assign a_timer_value_reg = mode16 ? {16'h0000, a_val16} : c32_r;

    chk_oneshot_stop: assert property (@(posedge clock) disable iff (!rst_b)
        (mode32 && a_mode_field == MODE_ONESHOT && a_en_r && !stall32 && c32_r == '0
         && !a_enable_set) |=> !a_en_r && ris_r[ST_A_TO])
        else $error("one-shot did not stop with flag");
    chk_flag_sticky: assert property (@(posedge clock) disable iff (!rst_b)
        (ris_r[ST_A_TO] && !irq_clear_reg[ST_A_TO]) |=> ris_r[ST_A_TO])
        else $error("time-out flag lost without clear");
    chk_match_sticky: assert property (@(posedge clock) disable iff (!rst_b)
        (ris_r[ST_A_MATCH] && !irq_clear_reg[ST_A_MATCH]) |=> ris_r[ST_A_MATCH])
        else $error("match flag lost without clear");
    chk_periodic_run: assert property (@(posedge clock) disable iff (!rst_b)
        (mode32 && a_mode_field == MODE_PERIODIC && a_en_r && !stall32 && c32_r == '0
         && !a_enable_clear) |=> a_en_r && c32_r == $past(a_interval_load_reg))
        else $error("periodic did not reload");
    chk_edge_count_stop: assert property (@(posedge clock) disable iff (!rst_b)
        (a_cm && !a_enable_set) |=> !a_en_r && ris_r[ST_A_MATCH])
        else $error("edge count did not stop");

endmodule
`default_nettype wire

// ===== core/gp_timer_pkg.sv
/*
 * Constants shared by the general purpose timer: configuration codes,
 * half mode codes, event select codes, reset values and RTC divider figures.
 * Assumes nothing of its surroundings.
 */
package gp_timer_pkg;

    // Global configuration codes.
    localparam logic [2:0] CFG_32BIT = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam int CFG_16BIT_BIT = 2;

    // Half mode field codes.
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_CAPTURE = 2'h3;

    // Event select codes.
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] EVT_BOTH = 2'h3;

    // Reset values and RTC start and roll values.
    localparam logic [15:0] LOAD16_RESET = 16'hFFFF;
    localparam logic [31:0] LOAD32_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
    localparam logic [31:0] RTC_ROLL = 32'h0000_0000;

    // RTC input clock and the one-second divide.
    localparam int RTC_CLK_HZ = 32768;
    localparam int RTC_DIV = RTC_CLK_HZ;

endpackage

// ===== core/gp_timer_half.sv
/*
 * One 16-bit timer half: one-shot, periodic, edge count, edge time and PWM.
 * Assumes synchronised capture pin input and configuration held stable
 * while the half is enabled.
 */
`timescale 1ns/100ps
`default_nettype none
module gp_timer_half
    import gp_timer_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Configuration.
    input wire logic active,
    input wire logic enable,
    input wire logic stall,
    input wire logic [1:0] half_mode_field,
    input wire logic capture_mode_bit,
    input wire logic alternate_mode_select_bit,
    input wire logic [1:0] event_select,
    input wire logic pwm_level_invert_bit,
    input wire logic [WIDTH-1:0] interval_load_reg,
    input wire logic [WIDTH-1:0] match_reg,
    input wire logic [7:0] prescale_reg,
    input wire logic [7:0] prescale_match_reg,
    // Synchronised capture pin.
    input wire logic pin_sync,
    // Status and results.
    output logic timeout_evt,
    output logic cap_match_evt,
    output logic cap_event_evt,
    output logic auto_disable,
    output logic [WIDTH-1:0] count_value,
    output logic [WIDTH-1:0] timer_value_reg,
    output logic pwm_out
);

    logic [WIDTH-1:0] cnt_r, cnt_nxt, cap_r, cap_nxt;
    logic [7:0] pre_r, pre_nxt;
    logic pin_d_r, pwm_r, pwm_nxt, running_r, running_nxt;
    logic edge_hit, is_pwm, is_cap, is_count, is_timer, tick;

    // Selected edge of the capture pin.
    always_comb
    begin
        case (event_select)
            EVT_RISE: edge_hit = pin_sync & ~pin_d_r;
            EVT_FALL: edge_hit = ~pin_sync & pin_d_r;
            EVT_BOTH: edge_hit = pin_sync ^ pin_d_r;
            default: edge_hit = 1'b0;
        endcase
    end

    assign is_pwm = active && alternate_mode_select_bit && !capture_mode_bit
        && half_mode_field == MODE_PERIODIC;
    assign is_cap = active && !alternate_mode_select_bit && half_mode_field == MODE_CAPTURE;
    assign is_count = is_cap && !capture_mode_bit;
    assign is_timer = active && !alternate_mode_select_bit
        && (half_mode_field == MODE_ONESHOT || half_mode_field == MODE_PERIODIC);
    // The prescaler only extends timer and PWM modes; zero means no division.
    assign tick = (pre_r == 8'h00);

    // Next state of counter, prescaler, capture and PWM level.
    always_comb
    begin
        cnt_nxt = cnt_r;
        pre_nxt = pre_r;
        cap_nxt = cap_r;
        pwm_nxt = pwm_r;
        running_nxt = enable;
        timeout_evt = 1'b0;
        cap_match_evt = 1'b0;
        cap_event_evt = 1'b0;
        auto_disable = 1'b0;
        if (!enable)
        begin
            // Disabled halves follow the load value so a restart begins there.
            cnt_nxt = interval_load_reg;
            pre_nxt = prescale_reg;
            pwm_nxt = 1'b0;
        end
        else if (is_count)
        begin
            if (edge_hit)
            begin
                if (cnt_r - 1'b1 == match_reg)
                begin
                    cnt_nxt = interval_load_reg;
                    cap_match_evt = 1'b1;
                    auto_disable = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
        end
        else if (is_cap)
        begin
            cnt_nxt = (cnt_r == '0) ? interval_load_reg : cnt_r - 1'b1;
            if (edge_hit)
            begin
                cap_nxt = cnt_r;
                cap_event_evt = 1'b1;
            end
        end
        else if ((is_pwm || is_timer) && !stall)
        begin
            if (!tick)
            begin
                pre_nxt = pre_r - 8'h01;
            end
            else if (cnt_r == '0)
            begin
                cnt_nxt = interval_load_reg;
                pre_nxt = prescale_reg;
                if (is_timer)
                begin
                    timeout_evt = 1'b1;
                    auto_disable = (half_mode_field == MODE_ONESHOT);
                end
            end
            else
            begin
                cnt_nxt = cnt_r - 1'b1;
                pre_nxt = prescale_reg;
            end
            if (is_pwm)
            begin
                // Match compares counter and prescaler together, 24 bits in all.
                if (cnt_r == interval_load_reg)
                begin
                    pwm_nxt = 1'b1;
                end
                else if (cnt_r == match_reg && pre_r == prescale_match_reg)
                begin
                    pwm_nxt = 1'b0;
                end
            end
        end
    end

    // Registers of the half.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_r <= LOAD16_RESET[WIDTH-1:0];
            cap_r <= LOAD16_RESET[WIDTH-1:0];
            pre_r <= 8'h00;
            pin_d_r <= 1'b0;
            pwm_r <= 1'b0;
            running_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            cap_r <= cap_nxt;
            pre_r <= pre_nxt;
            pin_d_r <= pin_sync;
            pwm_r <= pwm_nxt;
            running_r <= running_nxt;
        end
    end

    assign count_value = cnt_r;
    // Outside edge-time mode the value register shows the live count.
    assign timer_value_reg = (is_cap && capture_mode_bit) ? cap_r : cnt_r;
    assign pwm_out = (pwm_r && is_pwm) ^ pwm_level_invert_bit;

    chk_cap_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (enable && is_cap && capture_mode_bit && !edge_hit && $stable(capture_mode_bit))
        |=> $stable(cap_r)) else $error("capture value changed without edge");
    chk_pwm_no_flag: assert property (@(posedge clock) disable iff (!rst_b)
        is_pwm |-> !timeout_evt && !cap_match_evt && !cap_event_evt)
        else $error("status event raised in PWM mode");
    chk_cap_copy: assert property (@(posedge clock) disable iff (!rst_b)
        (enable && is_cap && capture_mode_bit && edge_hit) |=> cap_r == $past(cnt_r))
        else $error("capture did not copy count");
    chk_edge_wrap: assert property (@(posedge clock) disable iff (!rst_b)
        (enable && is_cap && capture_mode_bit && cnt_r == '0) |=> cnt_r == $past(interval_load_reg))
        else $error("edge time counter did not reload");

endmodule
`default_nettype wire

// ===== dv/pin_source.sv
/*
 * Capture pin source standing in for whatever drives the timer's pins.
 * Assumes the bench pulses go only while no edges are still pending.
 */
`timescale 1ns/100ps
`default_nettype none
module pin_source
(
    // Clock, reset and request.
    input wire logic clock,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [7:0] n_edges,
    // Pin and status.
    output logic pin,
    output logic busy
);
    logic [7:0] left_r;
    logic [2:0] tick_r;

    // One toggle every eight clocks, slow enough for the two-flop synchroniser.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            {pin, left_r, tick_r} <= '0;
        else if (go)
            {left_r, tick_r} <= {n_edges, 3'h0};
        else if (left_r != 8'h00)
        begin
            tick_r <= tick_r + 3'h1;
            if (tick_r == 3'h7)
                {pin, left_r} <= {~pin, left_r - 8'h01};
        end
    end
    assign busy = (left_r != 8'h00);
endmodule
`default_nettype wire

// ===== dv/tb_gp_timer.sv
/*
 * Self-checking bench for the general purpose timer.
 * Assumes the timer top and two capture pin source models beside it.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_gp_timer import gp_timer_pkg::*;;
    logic clock, rst_b, rtc_stall_override_bit, capture_pin_zero, capture_pin_one;
    logic [2:0] global_config_reg;
    logic [1:0] a_mode_field, b_mode_field, a_event_select, b_event_select;
    logic a_capture_mode_bit, b_capture_mode_bit, a_stall_bit, b_stall_bit;
    logic a_alternate_mode_select_bit, b_alternate_mode_select_bit;
    logic a_enable_set, a_enable_clear, b_enable_set, b_enable_clear;
    logic a_pwm_level_invert_bit, b_pwm_level_invert_bit;
    logic [31:0] a_interval_load_reg, a_match_reg, a_timer_value_reg;
    logic [15:0] b_interval_load_reg, b_match_reg, b_timer_value_reg, cap_v;
    logic [7:0] a_prescale_reg, b_prescale_reg, a_prescale_match_reg, b_prescale_match_reg;
    logic [5:0] irq_mask_reg, irq_clear_reg, raw_irq_status_reg, masked_irq_status_reg;
    logic a_enable_bit, b_enable_bit, a_pwm_out, b_pwm_out, go0, go1, busy0, busy1;
    logic [7:0] n_edges;
    int n_errors, checks, cycles, k;

    gp_timer #(.RTC_DIVIDE(4)) u_dut (.*);
    pin_source u_pin0 (.clock(clock), .rst_b(rst_b), .go(go0), .n_edges(n_edges),
        .pin(capture_pin_zero), .busy(busy0));
    pin_source u_pin1 (.clock(clock), .rst_b(rst_b), .go(go1), .n_edges(n_edges),
        .pin(capture_pin_one), .busy(busy1));

    // The 40 MHz clock.
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // The whole run needs under a thousand cycles, so this only cuts a hang short.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One-cycle pulses on enable set and clear (A set, A clear, B set, B clear) and flag clear.
    task automatic pulse(input logic [3:0] en, input logic [5:0] clr);
        @(posedge clock);
        {a_enable_set, a_enable_clear, b_enable_set, b_enable_clear} <= en;
        irq_clear_reg <= clr;
        @(posedge clock);
        {a_enable_set, a_enable_clear, b_enable_set, b_enable_clear} <= 4'h0;
        irq_clear_reg <= 6'h00;
        @(negedge clock);
    endtask

    // Edges on one pin, then time for the synchroniser and edge detect to see them.
    task automatic edges(input logic which, input logic [7:0] n);
        @(posedge clock);
        n_edges <= n;
        {go1, go0} <= {which, !which};
        @(posedge clock);
        {go1, go0} <= 2'h0;
        @(negedge clock);
        wait (!busy0 && !busy1);
        repeat (6) @(negedge clock);
    endtask

    // Edge count on half A: four edges reach the match, two more are ignored.
    task automatic edge_count();
        @(posedge clock);
        global_config_reg <= 3'h4;
        {a_mode_field, a_capture_mode_bit, a_event_select} <= {MODE_CAPTURE, 1'b0, EVT_BOTH};
        a_interval_load_reg <= 32'h0000_000A;
        a_match_reg <= 32'h0000_0006;
        irq_mask_reg <= 6'h02;
        pulse(4'h8, 6'h00);
        edges(1'b0, 8'h02);
        check(a_timer_value_reg, 32'h0000_0008);
        check(raw_irq_status_reg, 6'h00);
        edges(1'b0, 8'h04);
        check(raw_irq_status_reg, 6'h02);
        check(masked_irq_status_reg, 6'h02);
        check(a_enable_bit, 1'b0);
        check(a_timer_value_reg, 32'h0000_000A);
        pulse(4'h0, 6'h02);
        check(raw_irq_status_reg, 6'h00);
    endtask

    // Edge time on half B with rising edges only; a falling edge must not disturb it.
    task automatic edge_time();
        @(posedge clock);
        {b_mode_field, b_capture_mode_bit, b_event_select} <= {MODE_CAPTURE, 1'b1, EVT_RISE};
        irq_mask_reg <= 6'h20;
        pulse(4'h2, 6'h00);
        edges(1'b1, 8'h01);
        cap_v = b_timer_value_reg;
        check(raw_irq_status_reg, 6'h20);
        check(masked_irq_status_reg, 6'h20);
        check(cap_v > 16'hFE00 && cap_v < 16'hFFFF, 1'b1);
        edges(1'b1, 8'h01);
        check(b_timer_value_reg, cap_v);
        edges(1'b1, 8'h01);
        check(b_timer_value_reg < cap_v, 1'b1);
        check(b_enable_bit, 1'b1);
        pulse(4'h1, 6'h20);
    endtask

    // RTC with both stalls overridden: eight pin rises at divide 4 reach match 2, then roll.
    task automatic rtc();
        @(posedge clock);
        {global_config_reg, a_match_reg} <= {CFG_RTC, 32'h0000_0002};
        {a_stall_bit, b_stall_bit, rtc_stall_override_bit} <= 3'h7;
        pulse(4'h8, 6'h00);
        edges(1'b0, 8'h10);
        check(a_timer_value_reg, RTC_ROLL);
        check(raw_irq_status_reg, 6'h08);
        check(a_enable_bit, 1'b1);
        pulse(4'h4, 6'h08);
    endtask

    // 32-bit one-shot or periodic on A; only periodic times out again after a clear.
    task automatic shot(input logic [1:0] mode);
        @(posedge clock);
        {global_config_reg, a_mode_field} <= {CFG_32BIT, mode};
        a_interval_load_reg <= 32'h0000_0020;
        irq_mask_reg <= 6'h01;
        pulse(4'h8, 6'h00);
        for (k = 0; raw_irq_status_reg[0] !== 1'b1 && k < 200; k++)
            @(negedge clock);
        check(masked_irq_status_reg, 6'h01);
        repeat (40) @(negedge clock);
        check(raw_irq_status_reg, 6'h01);
        check(a_enable_bit, mode == MODE_PERIODIC);
        pulse(4'h0, 6'h01);
        check(raw_irq_status_reg, 6'h00);
        repeat (40) @(negedge clock);
        check(raw_irq_status_reg[0], mode == MODE_PERIODIC);
        pulse(4'h4, 6'h3F);
    endtask

    // PWM on B: load 16 and match 8 give 8 high cycles in every 17.
    task automatic pwm(input logic inv, input int exp_high);
        @(posedge clock);
        global_config_reg <= 3'h4;
        {b_alternate_mode_select_bit, b_capture_mode_bit, b_mode_field} <= 4'hA;
        b_pwm_level_invert_bit <= inv;
        b_interval_load_reg <= 16'h0010;
        b_match_reg <= 16'h0008;
        irq_mask_reg <= 6'h3F;
        pulse(4'h2, 6'h00);
        repeat (30) @(negedge clock);
        k = 0;
        repeat (68)
        begin
            @(negedge clock);
            k += b_pwm_out;
        end
        check(k, exp_high);
        check(raw_irq_status_reg, 6'h00);
        pulse(4'h1, 6'h00);
    endtask

    // Reset, then the scenarios in turn.
    initial
    begin
        rst_b = 1'b0;
        {global_config_reg, a_mode_field, b_mode_field, a_event_select, b_event_select} = '0;
        {a_capture_mode_bit, b_capture_mode_bit, a_alternate_mode_select_bit} = '0;
        {b_alternate_mode_select_bit, a_stall_bit, b_stall_bit, go0, go1} = '0;
        {a_enable_set, a_enable_clear, b_enable_set, b_enable_clear} = '0;
        {rtc_stall_override_bit, a_pwm_level_invert_bit, b_pwm_level_invert_bit} = '0;
        {a_prescale_reg, b_prescale_reg, a_prescale_match_reg, b_prescale_match_reg} = '0;
        {a_match_reg, b_match_reg, n_edges, irq_mask_reg, irq_clear_reg} = '0;
        a_interval_load_reg = LOAD32_RESET;
        b_interval_load_reg = LOAD16_RESET;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        check(b_timer_value_reg, LOAD16_RESET);
        check(a_timer_value_reg, LOAD32_RESET);
        edge_count();
        edge_time();
        shot(MODE_ONESHOT);
        shot(MODE_PERIODIC);
        pwm(1'b0, 32);
        pwm(1'b1, 36);
        rtc();
        tally_and_finish();
    end
endmodule
`default_nettype wire
